//--- hdl/dram_pin_pkg.sv
// Shared constants and types for the memory data-pin block.
// Assumes a core clock at 100 MHz and a strobe-rate link clock from the pin side.
package dram_pin_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int DQ_W = 16;           // Full data bus, two byte lanes
    localparam int LANE_W = 8;          // One byte lane
    localparam int LANES = 2;           // Lower and upper lane
    localparam int WR_W = DQ_W + LANES; // Write word: lane valid bits plus data
    localparam int FIFO_DEPTH = 16;     // Words in each buffer

    // ****************************************************************
    // Burst lengths and lane maps
    // ****************************************************************
    localparam logic [3:0] BURST_FULL = 4'h8;   // Beats without chop
    localparam logic [3:0] BURST_CHOP = 4'h4;   // Beats with chop
    localparam logic [1:0] LANE_X16 = 2'h3;     // Both lanes in use
    localparam logic [1:0] LANE_X8 = 2'h1;      // Lower lane only
    localparam logic [1:0] LANE_NONE = 2'h0;    // No lane in use

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [1:0] DQS_IDLE = 2'h0;             // Strobe level at rest
    localparam logic [DQ_W-1:0] DQ_IDLE = 16'h0000;     // Data level at rest

    // ****************************************************************
    // Link sequencer states
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_READ,
        ST_WRITE
    } link_state_t;

endpackage

//--- hdl/async_fifo.sv
// Dual-clock FIFO with gray-coded pointers.
// Assumes each side has its own reset, synchronous to its own clock.
`timescale 1ns/1ps
module async_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic wclk,
    input wire logic wrst,
    input wire logic w_valid,
    output logic w_ready,
    input wire logic [WIDTH-1:0] w_data,
    input wire logic rclk,
    input wire logic rrst,
    output logic r_valid,
    input wire logic r_ready,
    output logic [WIDTH-1:0] r_data
);
    localparam int AW = $clog2(DEPTH);

    // Binary to gray conversion
    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        to_gray = b ^ (b >> 1);
    endfunction

    logic [WIDTH-1:0] mem [DEPTH];  // Storage
    logic [AW:0] wbin;              // Write pointer, binary
    logic [AW:0] wgray;             // Write pointer, gray
    logic [AW:0] rbin;              // Read pointer, binary
    logic [AW:0] rgray;             // Read pointer, gray
    logic [AW:0] rg_s1;             // Read gray, first stage
    logic [AW:0] rg_s2;             // Read gray, second stage
    logic [AW:0] wg_s1;             // Write gray, first stage
    logic [AW:0] wg_s2;             // Write gray, second stage
    logic [AW:0] next_wbin;
    logic [AW:0] next_rbin;

    // Full when write gray is read gray with top two bits flipped
    assign w_ready = (wgray != {~rg_s2[AW:AW-1], rg_s2[AW-2:0]});
    assign r_valid = (rgray != wg_s2);
    assign r_data = mem[rbin[AW-1:0]];
    assign next_wbin = wbin + {{AW{1'b0}}, 1'b1};
    assign next_rbin = rbin + {{AW{1'b0}}, 1'b1};

    // ****************************************************************
    // Write side
    // ****************************************************************
    // Storage write
    always_ff @(posedge wclk) begin
        if (w_valid && w_ready) begin
            mem[wbin[AW-1:0]] <= w_data;
        end
    end

    // Write pointer
    always_ff @(posedge wclk or posedge wrst) begin
        if (wrst) begin
            wbin <= '0;
            wgray <= '0;
        end else if (w_valid && w_ready) begin
            wbin <= next_wbin;
            wgray <= to_gray(next_wbin);
        end
    end

    // Read pointer into write domain
    always_ff @(posedge wclk or posedge wrst) begin
        if (wrst) begin
            rg_s1 <= '0;
            rg_s2 <= '0;
        end else begin
            rg_s1 <= rgray;
            rg_s2 <= rg_s1;
        end
    end

    // ****************************************************************
    // Read side
    // ****************************************************************
    // Read pointer
    always_ff @(posedge rclk or posedge rrst) begin
        if (rrst) begin
            rbin <= '0;
            rgray <= '0;
        end else if (r_valid && r_ready) begin
            rbin <= next_rbin;
            rgray <= to_gray(next_rbin);
        end
    end

    // Write pointer into read domain
    always_ff @(posedge rclk or posedge rrst) begin
        if (rrst) begin
            wg_s1 <= '0;
            wg_s2 <= '0;
        end else begin
            wg_s1 <= wgray;
            wg_s2 <= wg_s1;
        end
    end

endmodule // async_fifo

//--- hdl/dram_data_pins.sv
// Data-side pin logic of the memory: reset pin, data bus, strobes, termination strobe.
// Assumes pins on the link side are timed to link_clk; core user side runs on clk.
`timescale 1ns/1ps
// Summary of operation
// - Low reset pin resets asynchronously
// - Memory drives strobes on reads, controller on writes
// - Read strobe edges aligned, write strobe centred; the controller model drives the write strobe edge aligned
// - Lower strobe times lower lane, upper upper
// - Strobes strictly differential, never single ended
// - Termination strobe exists on eight-bit only
// - Mode bit set: strobe-like termination on pair
// - Mode bit clear: data mask, complement unused
// - Fully masked write beats are discarded
// - Address bit twelve low chops burst
module dram_data_pins (
    input wire logic clk,
    input wire logic rst,
    input wire logic reset_n,
    input wire logic link_clk,
    input wire logic mr1_tdqs,
    input wire logic org_x16,
    input wire logic bc_otf_en,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_write,
    input wire logic cmd_a12,
    input wire logic rd_valid,
    output logic rd_ready,
    input wire logic [dram_pin_pkg::DQ_W-1:0] rd_data,
    output logic wr_valid,
    input wire logic wr_ready,
    output logic [dram_pin_pkg::DQ_W-1:0] wr_data,
    output logic [dram_pin_pkg::LANES-1:0] wr_lanes,
    output logic wr_overrun,
    output logic rd_underrun,
    output logic in_reset,
    input wire logic [dram_pin_pkg::DQ_W-1:0] dq_in,
    output logic [dram_pin_pkg::DQ_W-1:0] dq_out,
    output logic [dram_pin_pkg::LANES-1:0] dq_oe,
    input wire logic [dram_pin_pkg::LANES-1:0] dqs_in,
    input wire logic [dram_pin_pkg::LANES-1:0] dqs_n_in,
    output logic [dram_pin_pkg::LANES-1:0] dqs_out,
    output logic [dram_pin_pkg::LANES-1:0] dqs_n_out,
    output logic [dram_pin_pkg::LANES-1:0] dqs_oe,
    input wire logic [dram_pin_pkg::LANES-1:0] dm_in,
    input wire logic odt_in,
    output logic [dram_pin_pkg::LANES-1:0] dqs_term,
    output logic tdqs_term,
    output logic tdqs_n_term
);
    import dram_pin_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic arst;                     // Combined asynchronous reset
    logic core_rs1;                 // Core reset release, first stage
    logic core_rs2;                 // Core reset release, second stage
    logic core_rst;                 // Core domain reset
    logic link_rs1;                 // Link reset release, first stage
    logic link_rs2;                 // Link reset release, second stage
    logic link_rst;                 // Link domain reset
    logic [1:0] cfg_s1;             // Config levels, first stage
    logic [1:0] cfg_s2;             // Config levels, second stage
    logic cmd_req_tgl;              // Command request toggle, core
    logic cmd_write_q;              // Held command direction
    logic cmd_chop_q;               // Held chop decision
    logic ack_s1;                   // Ack toggle, first stage
    logic ack_s2;                   // Ack toggle, second stage
    logic req_s1;                   // Request toggle, first stage
    logic req_s2;                   // Request toggle, second stage
    logic req_s3;                   // Request toggle, edge reference
    logic ack_tgl;                  // Burst done toggle, link
    logic new_cmd;                  // Command arrived in link domain
    link_state_t state;             // Link sequencer state
    logic [3:0] beat_cnt;           // Beat within burst
    logic chop_l;                   // Current burst is chopped
    logic [3:0] burst_last;         // Index of last beat
    logic tdqs_en;                  // Termination strobe selected
    logic dm_en;                    // Data mask selected
    logic [LANES-1:0] lane_mask;    // Lanes of this organization
    logic [LANES-1:0] lane_ok;      // Lanes kept in this write beat
    logic [LANES-1:0] next_dqs;     // Strobe level for next beat
    logic wf_push;                  // Write buffer push
    logic wf_ready;                 // Write buffer has room
    logic rf_valid;                 // Read buffer has a word
    logic rf_pop;                   // Read buffer pop
    logic [DQ_W-1:0] rf_data;       // Read buffer head
    logic [WR_W-1:0] wf_out;        // Write buffer head
    logic ovr_l;                    // Overrun, link sticky
    logic und_l;                    // Underrun, link sticky
    logic [1:0] flag_s1;            // Flags, first stage
    logic [1:0] flag_s2;            // Flags, second stage

    // ****************************************************************
    // Reset
    // ****************************************************************
    // Pin low resets at once, with no clock needed
    assign arst = rst | ~reset_n;

    // Core reset: asserts at once, releases after two edges
    always_ff @(posedge clk or posedge arst) begin
        if (arst) begin
            core_rs1 <= 1'b0;
            core_rs2 <= 1'b0;
        end else begin
            core_rs1 <= 1'b1;
            core_rs2 <= core_rs1;
        end
    end

    // Link reset, same scheme on the link clock
    always_ff @(posedge link_clk or posedge arst) begin
        if (arst) begin
            link_rs1 <= 1'b0;
            link_rs2 <= 1'b0;
        end else begin
            link_rs1 <= 1'b1;
            link_rs2 <= link_rs1;
        end
    end

    // Normal operation relies on the pin being held high
    assign core_rst = ~core_rs2;
    assign link_rst = ~link_rs2;
    assign in_reset = core_rst;

    // ****************************************************************
    // Core side command port
    // ****************************************************************
    // Ready once the link has answered the last request
    assign cmd_ready = (ack_s2 == cmd_req_tgl) && !core_rst;

    // Take a command and hold its fields until answered
    always_ff @(posedge clk or posedge core_rst) begin
        if (core_rst) begin
            cmd_req_tgl <= 1'b0;
            cmd_write_q <= 1'b0;
            cmd_chop_q <= 1'b0;
        end else if (cmd_valid && cmd_ready) begin
            cmd_req_tgl <= ~cmd_req_tgl;
            cmd_write_q <= cmd_write;
            cmd_chop_q <= bc_otf_en && !cmd_a12;
        end
    end

    // Ack toggle and link flags into the core domain
    always_ff @(posedge clk or posedge core_rst) begin
        if (core_rst) begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
            flag_s1 <= 2'h0;
            flag_s2 <= 2'h0;
        end else begin
            ack_s1 <= ack_tgl;
            ack_s2 <= ack_s1;
            flag_s1 <= {und_l, ovr_l};
            flag_s2 <= flag_s1;
        end
    end

    assign wr_overrun = flag_s2[0];
    assign rd_underrun = flag_s2[1];

    // ****************************************************************
    // Link side crossing and configuration
    // ****************************************************************
    // Request toggle and quasi-static config into link domain
    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_s3 <= 1'b0;
            cfg_s1 <= 2'h0;
            cfg_s2 <= 2'h0;
        end else begin
            req_s1 <= cmd_req_tgl;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
            cfg_s1 <= {org_x16, mr1_tdqs};
            cfg_s2 <= cfg_s1;
        end
    end

    assign new_cmd = req_s2 ^ req_s3;
    // Termination strobe only on the eight-bit organization
    assign tdqs_en = cfg_s2[0] && !cfg_s2[1];
    assign dm_en = !tdqs_en;
    // Lower strobe serves lower lane, upper only on x16
    assign lane_mask = cfg_s2[1] ? LANE_X16 : LANE_X8;
    assign burst_last = (chop_l ? BURST_CHOP : BURST_FULL) - 4'h1;

    // ****************************************************************
    // Link sequencer
    // ****************************************************************
    // Start a burst on a new command, end it after its beats
    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            state <= ST_IDLE;
            beat_cnt <= 4'h0;
            chop_l <= 1'b0;
            ack_tgl <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (new_cmd) begin
                        state <= cmd_write_q ? ST_WRITE : ST_READ;
                        chop_l <= cmd_chop_q;
                        beat_cnt <= 4'h0;
                    end
                end
                ST_READ, ST_WRITE: begin
                    if (beat_cnt == burst_last) begin
                        state <= ST_IDLE;
                        ack_tgl <= ~ack_tgl;
                    end else begin
                        beat_cnt <= beat_cnt + 4'h1;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // Read drive
    // ****************************************************************
    assign rf_pop = (state == ST_READ) && rf_valid;
    // Strobe flips with every beat, so edges meet data edges
    assign next_dqs = (state == ST_READ) ? (~dqs_out & lane_mask) : DQS_IDLE;

    // Drive data and strobe pairs during read bursts only
    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            dq_out <= DQ_IDLE;
            dq_oe <= LANE_NONE;
            dqs_oe <= LANE_NONE;
            dqs_out <= DQS_IDLE;
            dqs_n_out <= ~DQS_IDLE;
        end else begin
            dq_out <= rf_pop ? rf_data : DQ_IDLE;
            dq_oe <= (state == ST_READ) ? lane_mask : LANE_NONE;
            dqs_oe <= (state == ST_READ) ? lane_mask : LANE_NONE;
            dqs_out <= next_dqs;
            dqs_n_out <= ~next_dqs;
        end
    end

    // Underrun when a read beat finds no data
    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            und_l <= 1'b0;
        end else if (state == ST_READ && !rf_valid) begin
            und_l <= 1'b1;
        end
    end

    // ****************************************************************
    // Write capture
    // ****************************************************************
    // A lane counts only with a true differential strobe and, when the data mask is selected, no mask
    always_comb begin
        lane_ok = LANE_NONE;
        if (state == ST_WRITE) begin
            lane_ok = (dqs_in ^ dqs_n_in) & lane_mask;
            if (dm_en) begin
                lane_ok = lane_ok & ~dm_in;
            end
        end
    end

    assign wf_push = |lane_ok;

    // Overrun when a kept beat finds the buffer full
    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            ovr_l <= 1'b0;
        end else if (wf_push && !wf_ready) begin
            ovr_l <= 1'b1;
        end
    end

    // ****************************************************************
    // Termination
    // ****************************************************************
    // Terminate while ODT is high and not reading; termination strobe mirrors strobe
    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            dqs_term <= LANE_NONE;
            tdqs_term <= 1'b0;
            tdqs_n_term <= 1'b0;
        end else begin
            dqs_term <= (odt_in && state != ST_READ) ? lane_mask : LANE_NONE;
            tdqs_term <= odt_in && state != ST_READ && tdqs_en;
            tdqs_n_term <= odt_in && state != ST_READ && tdqs_en;
        end
    end

    // ****************************************************************
    // Buffers
    // ****************************************************************
    // Write words: link to core
    async_fifo #(.WIDTH(WR_W), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
        .wclk(link_clk),
        .wrst(link_rst),
        .w_valid(wf_push),
        .w_ready(wf_ready),
        .w_data({lane_ok, dq_in}),
        .rclk(clk),
        .rrst(core_rst),
        .r_valid(wr_valid),
        .r_ready(wr_ready),
        .r_data(wf_out)
    );

    assign wr_data = wf_out[DQ_W-1:0];
    assign wr_lanes = wf_out[WR_W-1:DQ_W];

    // Read words: core to link
    async_fifo #(.WIDTH(DQ_W), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
        .wclk(clk),
        .wrst(core_rst),
        .w_valid(rd_valid),
        .w_ready(rd_ready),
        .w_data(rd_data),
        .rclk(link_clk),
        .rrst(link_rst),
        .r_valid(rf_valid),
        .r_ready(rf_pop),
        .r_data(rf_data)
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_reset_pin;
        @(posedge clk) disable iff (rst)
        !reset_n |-> in_reset && !cmd_ready;
    endproperty
    a_reset_pin: assert property (p_reset_pin) else $error("pin reset not applied");

    property p_write_no_drive;
        @(posedge link_clk) disable iff (link_rst)
        (state == ST_WRITE) |=> (dq_oe == LANE_NONE) && (dqs_oe == LANE_NONE);
    endproperty
    a_write_no_drive: assert property (p_write_no_drive) else $error("drove bus in write");

    property p_read_toggle;
        @(posedge link_clk) disable iff (link_rst)
        dqs_oe[0] && $past(dqs_oe[0]) |-> dqs_out[0] != $past(dqs_out[0]);
    endproperty
    a_read_toggle: assert property (p_read_toggle) else $error("read strobe not toggling");

    property p_x8_upper_quiet;
        @(posedge link_clk) disable iff (link_rst)
        !cfg_s2[1] && $past(!cfg_s2[1]) |-> !dq_oe[1] && !dqs_oe[1] && !lane_ok[1];
    endproperty
    a_x8_upper_quiet: assert property (p_x8_upper_quiet) else $error("upper lane used on x8");

    property p_diff_pair;
        @(posedge link_clk) disable iff (link_rst)
        dqs_oe != LANE_NONE |-> (dqs_out ^ dqs_n_out) == 2'h3;
    endproperty
    a_diff_pair: assert property (p_diff_pair) else $error("strobe pair not complementary");

    property p_x16_no_tdqs;
        @(posedge link_clk) disable iff (link_rst)
        $past(cfg_s2[1]) |-> !tdqs_term && !tdqs_n_term;
    endproperty
    a_x16_no_tdqs: assert property (p_x16_no_tdqs) else $error("termination strobe on x16");

    property p_tdqs_follow;
        @(posedge link_clk) disable iff (link_rst)
        $past(tdqs_en) |-> (tdqs_term == dqs_term[0]) && (tdqs_n_term == dqs_term[0]);
    endproperty
    a_tdqs_follow: assert property (p_tdqs_follow) else $error("termination strobe mismatch");

    property p_tdqs_off;
        @(posedge link_clk) disable iff (link_rst)
        !$past(tdqs_en) |-> !tdqs_term && !tdqs_n_term;
    endproperty
    a_tdqs_off: assert property (p_tdqs_off) else $error("termination strobe while masking");

    property p_mask_drop;
        @(posedge link_clk) disable iff (link_rst)
        (state == ST_WRITE) && dm_en && ((dm_in & lane_mask) == lane_mask) |-> !wf_push;
    endproperty
    a_mask_drop: assert property (p_mask_drop) else $error("masked beat kept");

    property p_chop_len;
        @(posedge link_clk) disable iff (link_rst)
        $rose(state == ST_WRITE) && chop_l |-> (state == ST_WRITE)[*4] ##1 (state == ST_IDLE);
    endproperty
    a_chop_len: assert property (p_chop_len) else $error("chopped burst not four beats");

    property p_full_len;
        @(posedge link_clk) disable iff (link_rst)
        $rose(state == ST_READ) && !chop_l |-> (state == ST_READ)[*8] ##1 (state == ST_IDLE);
    endproperty
    a_full_len: assert property (p_full_len) else $error("full burst not eight beats");

endmodule // dram_data_pins

//--- verif/ctrl_model.sv
// Controller-side model that drives the link pins of the data block.
// Assumes the bench chooses when to drive a write burst; pins move on falling link_clk.
`timescale 1ns/1ps
module ctrl_model (
    input wire logic link_clk,
    input wire logic drive,
    input wire logic [1:0] mask,
    input wire logic [15:0] word,
    output logic [15:0] dq_in,
    output logic [1:0] dqs_in,
    output logic [1:0] dqs_n_in,
    output logic [1:0] dm_in
);
    // ****************************************************************
    // Link pin drive
    // ****************************************************************
    // Strobe toggles on the same falling edge as the data, so its edge meets the data edge
    always @(negedge link_clk) begin
        if (drive) begin
            dq_in <= word;
            dqs_in <= ~dqs_in;
            dqs_n_in <= dqs_in;
            dm_in <= mask;
        end else begin // Released bus shows inverse, strobe pair equal
            dq_in <= ~word;
            dqs_in <= 2'h0;
            dqs_n_in <= 2'h0;
            dm_in <= ~mask;
        end
    end
endmodule // ctrl_model

//--- verif/ddr3_data_strobe_and_reset_pins_test.sv
// Bench for the memory data-pin block: core side driven here, link pins by the model.
// Assumes the controller model and the design files are compiled before it.
`timescale 1ns/1ps
module ddr3_data_strobe_and_reset_pins_test;
    import dram_pin_pkg::*;
    logic clk = 0, rst = 1, reset_n = 1, link_clk = 0; // Clocks and resets
    logic mr1_tdqs = 0, org_x16 = 1, bc_otf_en = 0, cmd_valid = 0, cmd_write = 0, cmd_a12 = 1;
    logic rd_valid = 0, wr_ready = 1, odt_in = 0, drive = 0; // Core and model controls
    logic [1:0] mask = 2'h0;
    logic [15:0] rd_data = 16'h0000, word = 16'h0000;
    logic cmd_ready, rd_ready, wr_valid, wr_overrun, rd_underrun, in_reset, tdqs_term, tdqs_n_term;
    logic [15:0] wr_data, dq_in, dq_out;
    logic [1:0] wr_lanes, dq_oe, dqs_in, dqs_n_in, dqs_out, dqs_n_out, dqs_oe, dm_in, dqs_term;
    logic [17:0] rq[$], wq[$]; // Seen read beats and write words
    int miscompares = 0, checks_done = 0;
    initial forever #5 clk = ~clk;
    // Link clock, phase unrelated to clk
    initial begin
        #23;
        forever #40 link_clk = ~link_clk;
    end
    dram_data_pins uut (.clk, .rst, .reset_n, .link_clk, .mr1_tdqs, .org_x16, .bc_otf_en,
        .cmd_valid, .cmd_ready, .cmd_write, .cmd_a12, .rd_valid, .rd_ready, .rd_data, .wr_valid,
        .wr_ready, .wr_data, .wr_lanes, .wr_overrun, .rd_underrun, .in_reset, .dq_in, .dq_out,
        .dq_oe, .dqs_in, .dqs_n_in, .dqs_out, .dqs_n_out, .dqs_oe, .dm_in, .odt_in, .dqs_term,
        .tdqs_term, .tdqs_n_term);
    ctrl_model model (.link_clk, .drive, .mask, .word, .dq_in, .dqs_in, .dqs_n_in, .dm_in);
    // ****************************************************************
    // Monitors and shared tasks
    // ****************************************************************
    // Beats the block drives on the link
    always @(negedge link_clk) begin
        if (dq_oe !== 2'h0) begin
            rq.push_back({dq_oe, dq_out});
            check("strobe pair", {16'h0, dqs_n_out}, {16'h0, ~dqs_out});
            check("strobe enable", {16'h0, dqs_oe}, {16'h0, dq_oe});
        end
    end
    // Words leaving the write buffer
    always @(posedge clk) begin
        if (wr_valid === 1'b1 && wr_ready === 1'b1) wq.push_back({wr_lanes, wr_data});
    end
    task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic setup(input logic x16, input logic chop, input logic tdqs);
        org_x16 = x16;
        bc_otf_en = chop;
        cmd_a12 = ~chop;
        mr1_tdqs = tdqs;
        repeat (4) @(posedge link_clk);
        @(negedge clk);
    endtask
    task automatic command(input logic w);
        cmd_write = w;
        cmd_valid = 1;
        while (cmd_ready !== 1'b1) @(negedge clk);
        @(negedge clk);
        cmd_valid = 0;
        do @(negedge clk); while (cmd_ready !== 1'b1);
        repeat (8) @(negedge clk);
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic test_read(input logic x16, input logic chop);
        int n;
        logic [15:0] m;
        n = chop ? 4 : 8;
        m = x16 ? 16'hFFFF : 16'h00FF;
        setup(x16, chop, 1'b0);
        for (int i = 0; i < n; i++) begin
            rd_valid = 1;
            rd_data = 16'hA500 + 16'(i);
            while (rd_ready !== 1'b1) @(negedge clk);
            @(negedge clk);
        end
        rd_valid = 0;
        rq.delete();
        command(1'b0);
        check("read beats", 18'(rq.size()), 18'(n));
        foreach (rq[i])
            check("read beat", rq[i] & {2'h3, m}, {x16 ? LANE_X16 : LANE_X8, 16'hA500 + 16'(i) & m});
        check("underrun", {17'h0, rd_underrun}, 18'h0);
        $display("read test done");
    endtask
    task automatic test_write(input logic x16, chop, tdqs, input logic [1:0] dm, lanes);
        setup(x16, chop, tdqs);
        word = 16'h3CC3;
        mask = dm;
        drive = 1;
        wr_ready = 0;
        repeat (4) @(posedge link_clk);
        rq.delete();
        wq.delete();
        command(1'b1);
        wr_ready = 1;
        repeat (8) @(negedge clk);
        drive = 0;
        check("write words", 18'(wq.size()), !lanes ? 18'h0 : chop ? 18'h4 : 18'h8);
        check("overrun", {17'h0, wr_overrun}, 18'h0);
        foreach (wq[i]) check("write word", wq[i], {lanes, 16'h3CC3});
        check("bus released on write", 18'(rq.size()), 18'h0);
        $display("write test done");
    endtask
    task automatic test_term(input logic tdqs);
        setup(1'b0, 1'b0, tdqs);
        odt_in = 1;
        repeat (4) @(posedge link_clk);
        @(negedge clk);
        check("strobe term", {16'h0, dqs_term}, {16'h0, LANE_X8});
        check("tdqs term", {16'h0, tdqs_term, tdqs_n_term}, {16'h0, tdqs, tdqs});
        odt_in = 0;
        $display("termination test done");
    endtask
    task automatic test_reset();
        reset_n = 0;
        repeat (3) @(negedge clk);
        check("in reset", {17'h0, in_reset}, 18'h1);
        check("no command", {17'h0, cmd_ready}, 18'h0);
        repeat (20) @(negedge clk);
        reset_n = 1;
        do @(negedge clk); while (in_reset !== 1'b0);
        $display("reset test done");
    endtask
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (16) @(negedge clk);
        rst = 0;
        do @(negedge clk); while (in_reset !== 1'b0);
        test_read(1'b1, 1'b0);
        test_read(1'b0, 1'b1);
        test_write(1'b1, 1'b0, 1'b0, 2'h1, 2'h2);
        test_write(1'b0, 1'b1, 1'b1, 2'h1, 2'h1);
        test_write(1'b0, 1'b0, 1'b0, 2'h1, 2'h0);
        test_term(1'b1);
        test_term(1'b0);
        test_reset();
        test_read(1'b1, 1'b1);
        end_sim();
    end
    // Watchdog
    initial begin
        #200000;
        miscompares++;
        end_sim();
    end
endmodule // ddr3_data_strobe_and_reset_pins_test
